// File: common/rxd_pkg.sv
/*
 Package for the receive descriptor engine: register offsets, descriptor
 bit positions, length limits, state codes and carrier structs.
 Assumes a byte-addressed host memory port and one 20 MHz clock.
*/
`default_nettype none
package rxd_pkg;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BASE   = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h08;
  localparam logic [7:0] REG_CUR    = 8'h0C;
  localparam logic [7:0] REG_FRAMES = 8'h10;
  localparam int CTRL_EN   = 0;
  localparam int CTRL_PASS = 1;
  localparam int B_OWN     = 31;
  localparam int B_FIRST   = 30;
  localparam int B_LAST    = 29;
  localparam int B_IPBAD   = 28;
  localparam int B_TCPBAD  = 27;
  localparam int B_UDPBAD  = 26;
  localparam int B_ERRSUM  = 25;
  localparam int B_MCAST   = 24;
  localparam int B_PHYERR  = 19;
  localparam int B_OVERLEN = 18;
  localparam int B_RUNT    = 17;
  localparam int B_CRC     = 16;
  localparam int B_TYPE    = 15;
  localparam int B_WRAP    = 25;
  localparam int LEN_W     = 11;
  localparam logic [15:0] MAX_LEN   = 16'h07D0;
  localparam logic [15:0] TYPE_THR  = 16'h05DC;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_FETCH = 5'h02,
    S_DATA  = 5'h04,
    S_WBACK = 5'h08,
    S_NEXT  = 5'h10
  } rxd_state_type;
  typedef struct packed {
    logic ip_bad;
    logic tcp_bad;
    logic udp_bad;
    logic mcast;
    logic phy_err;
    logic crc_err;
    logic runt;
    logic [15:0] type_len;
  } rxd_stat_type;
  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rxd_mem_type;
endpackage
`default_nettype wire

// File: dv/rxd_engine_tb.sv
/*
 Bench for rxd_engine: register access, status rows, split, long and
 skipped frames. Assumes the memory model answers every request.
*/
`timescale 1ns/100ps
`default_nettype none
module rxd_engine_tb;
  logic clk, sys_rst, reg_wr, reg_rd, mem_req, mem_ack, rx_valid, rx_ready, rx_last, hi;
  logic [7:0]            reg_addr;
  logic [31:0]           reg_wdata, reg_rdata, mem_rdata, rx_data, m;
  logic [2:0]            rx_bytes;
  logic [3:0]            lat;
  rxd_pkg::rxd_stat_type rx_stat;
  rxd_pkg::rxd_mem_type  mem_cmd;
  int                    err_total, num_checks;
  typedef struct packed { logic [22:0] st; logic [31:0] w; } rxd_row_type;
  rxd_row_type rows [9] = '{
    '{{7'h40, 16'h0000}, 32'h7000_0004}, '{{7'h20, 16'h0000}, 32'h6800_0004},
    '{{7'h10, 16'h0000}, 32'h6400_0004}, '{{7'h08, 16'h0000}, 32'h6100_0004},
    '{{7'h04, 16'h0000}, 32'h6008_0004}, '{{7'h02, 16'h0000}, 32'h6201_0000},
    '{{7'h01, 16'h0000}, 32'h6202_0000}, '{{7'h00, 16'h05DD}, 32'h6000_8004},
    '{{7'h00, 16'h05DC}, 32'h6000_0004}};
  rxd_engine u_rxd_engine (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_last(rx_last), .rx_bytes(rx_bytes), .rx_stat(rx_stat));
  rxd_mem_model u_rxd_mem_model (.clk(clk), .mem_req(mem_req), .mem_cmd(mem_cmd), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  task automatic arm(input int k, input logic [31:0] w1, input logic [31:0] nxt);
    u_rxd_mem_model.mem[k] = 32'h8000_0000;
    u_rxd_mem_model.mem[k+1] = w1;
    u_rxd_mem_model.mem[k+2] = 32'h0000_0100;
    u_rxd_mem_model.mem[k+3] = nxt;
  endtask
  task automatic send(input int n, input logic [22:0] st);
    logic ok;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= 32'hA000_0000 + 32'(i);
      rx_last <= (i == n - 1);
      rx_stat <= st;
      do begin
        @(negedge clk);
        ok = rx_ready;
        @(posedge clk);
      end while (!ok);
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  // waits for the engine to hand a descriptor back
  // a handback that never comes counts as a mismatch
  task automatic wt(input int k);
    int n;
    n = 0;
    while (u_rxd_mem_model.mem[k][31] && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n == 4000) begin
      err_total++;
      $display("[FAIL] %0t own %h exp %h", $time, 1'b1, 1'b0);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #3000000;
    err_total++;
    final_report();
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, rx_valid, rx_last} = 5'h10;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rx_data = 32'h0;
    rx_bytes = 3'h4;
    rx_stat = '0;
    lat = 4'h0;
    err_total = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(rxd_pkg::REG_CTRL, 32'h0);
    rd(rxd_pkg::REG_BASE, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    arm(16, 32'h0200_0010, 32'h40);
    wr(rxd_pkg::REG_BASE, 32'h40);
    rd(rxd_pkg::REG_BASE, 32'h40);
    wr(rxd_pkg::REG_CTRL, 32'h3);
    foreach (rows[i]) begin
      lat = i[0] ? 4'h3 : 4'h0;
      arm(16, 32'h0200_0010, 32'h40);
      send(1, rows[i].st);
      wt(16);
      m = rows[i].w[25] ? 32'hFFFF_F800 : 32'hFFFF_FFFF;
      chk(u_rxd_mem_model.mem[16] & m, rows[i].w & m);
      chk(u_rxd_mem_model.mem[64], 32'hA000_0000);
    end
    rd(rxd_pkg::REG_FRAMES, 32'h9);
    arm(16, 32'h0200_0004, 32'h40);
    fork
      send(2, '0);
      begin
        wt(16);
        chk(u_rxd_mem_model.mem[16], 32'h4000_0000);
        hi = 1'b0;
        repeat (20) begin
          @(negedge clk);
          hi = hi | rx_ready;
        end
        chk({31'h0, hi}, 32'h0);
        arm(16, 32'h0200_0004, 32'h40);
        wt(16);
        chk(u_rxd_mem_model.mem[16], 32'h2000_0008);
        chk(u_rxd_mem_model.mem[64], 32'hA000_0001);
      end
    join
    arm(16, 32'h0200_07FC, 32'h40);
    send(502, '0);
    wt(16);
    chk(u_rxd_mem_model.mem[16] & 32'hFFFF_F800, 32'h6204_0000);
    chk(u_rxd_mem_model.mem[565], 32'hA000_01F5);
    arm(16, 32'h0000_0000, 32'h60);
    arm(24, 32'h0200_0010, 32'h40);
    send(1, '0);
    wt(24);
    chk(u_rxd_mem_model.mem[24], 32'h6000_0004);
    chk(u_rxd_mem_model.mem[16], 32'h8000_0000);
    // runt with bad-pass off: descriptor kept, reused for the next frame
    wr(rxd_pkg::REG_CTRL, 32'h1);
    arm(24, 32'h0200_0010, 32'h40);
    send(1, {7'h01, 16'h0000});
    repeat (40) @(negedge clk);
    chk(u_rxd_mem_model.mem[24], 32'h8000_0000);
    chk({31'h0, rx_ready}, 32'h1);
    send(1, '0);
    wt(24);
    chk(u_rxd_mem_model.mem[24], 32'h6000_0004);
    // mid-run reset
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(rxd_pkg::REG_CTRL, 32'h0);
    rd(rxd_pkg::REG_FRAMES, 32'h0);
    rd(rxd_pkg::REG_STAT, 32'h41);
    rd(rxd_pkg::REG_CUR, 32'h0);
    chk({31'h0, mem_req}, 32'h0);
    final_report();
  end
endmodule // rxd_engine_tb
`default_nettype wire

// File: dv/rxd_mem_model.sv
/*
 Host memory model: descriptor lists and receive buffers, 4 KB of words.
 Assumes one request at a time, held with its command until mem_ack.
*/
`timescale 1ns/100ps
`default_nettype none
module rxd_mem_model (
  input  wire logic                 clk,
  input  wire logic                 mem_req,
  input  wire rxd_pkg::rxd_mem_type mem_cmd,
  input  wire logic [3:0]           lat,
  output logic                      mem_ack,
  output logic [31:0]               mem_rdata
);
  logic [31:0] mem [0:1023]; // host keeps words aligned
  logic [3:0]  cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    cnt = 4'h0;
    foreach (mem[i]) mem[i] = 32'h0;
  end
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    // stale read data keeps toggling so it never passes for valid
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt >= lat) begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_cmd.we) mem[mem_cmd.addr[11:2]] <= mem_cmd.wdata;
        else mem_rdata <= mem[mem_cmd.addr[11:2]];
      end else cnt <= cnt + 4'h1;
    end
  end
endmodule // rxd_mem_model
`default_nettype wire

// File: src/rxd_engine.sv
/*
 Receive descriptor engine: walks the descriptor list in host memory,
 fills buffers from the receive word stream and writes status back.
 Assumes memory answers each held request with a one-cycle mem_ack,
 read data valid beside it, and status inputs valid with rx_last.
*/
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module rxd_engine (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  output logic                      mem_req,
  output rxd_pkg::rxd_mem_type      mem_cmd,
  input  wire logic                 mem_ack,
  input  wire logic [31:0]          mem_rdata,
  input  wire logic                 rx_valid,
  output logic                      rx_ready,
  input  wire logic [31:0]          rx_data,
  input  wire logic                 rx_last,
  input  wire logic [2:0]           rx_bytes,
  input  wire rxd_pkg::rxd_stat_type rx_stat
);
  rxd_pkg::rxd_state_type st_q, st_d;
  logic [31:0] base_q, base_d, cur_q, cur_d, buf_q, buf_d, nxt_q, nxt_d;
  logic [31:0] addr_q, addr_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic [15:0] cnt_q, cnt_d, frames_q, frames_d;
  logic [10:0] size_q, size_d, off_q, off_d;
  logic [1:0]  idx_q, idx_d;
  logic        en_q, en_d, pass_q, pass_d, own_q, own_d, wrap_q, wrap_d;
  logic        req_q, req_d, we_q, we_d, first_q, first_d, fin_q, fin_d;
  rxd_pkg::rxd_stat_type stat_q, stat_d;
  logic        take, drop;

  function automatic logic [31:0] status_word(
    input logic first, input logic last, input rxd_pkg::rxd_stat_type s,
    input logic [15:0] len);
    logic [31:0] w;
    w = rxd_pkg::RST_WORD;
    w[rxd_pkg::B_FIRST] = first;
    w[rxd_pkg::B_LAST] = last;
    if (last) begin
      w[rxd_pkg::B_IPBAD] = s.ip_bad;
      w[rxd_pkg::B_TCPBAD] = s.tcp_bad;
      w[rxd_pkg::B_UDPBAD] = s.udp_bad;
      w[rxd_pkg::B_MCAST] = s.mcast;
      w[rxd_pkg::B_OVERLEN] = len > rxd_pkg::MAX_LEN;
      w[rxd_pkg::B_RUNT] = s.runt;
      w[rxd_pkg::B_CRC] = s.crc_err;
      w[rxd_pkg::B_ERRSUM] = s.crc_err | s.runt | (len > rxd_pkg::MAX_LEN);
      w[rxd_pkg::B_TYPE] = !s.runt && s.type_len > rxd_pkg::TYPE_THR;
      w[rxd_pkg::LEN_W-1:0] = len[rxd_pkg::LEN_W-1:0];
    end
    w[rxd_pkg::B_PHYERR] = s.phy_err;
    return w;
  endfunction

  assign take = (st_q == rxd_pkg::S_DATA) && !req_q && rx_valid;
  assign rx_ready = (st_q == rxd_pkg::S_DATA) && !req_q;
  // runts without bad-pass keep the descriptor; earlier buffers of a
  // long runt are already returned, which real runts never reach
  assign drop = stat_q.runt && !pass_q;
  assign mem_req = req_q;
  assign mem_cmd = '{we: we_q, addr: addr_q, wdata: wdata_q};
  assign reg_rdata = rdata_q;

  always_comb begin
    st_d = st_q;
    base_d = base_q;
    cur_d = cur_q;
    buf_d = buf_q;
    nxt_d = nxt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    cnt_d = cnt_q;
    frames_d = frames_q;
    size_d = size_q;
    off_d = off_q;
    idx_d = idx_q;
    en_d = en_q;
    pass_d = pass_q;
    own_d = own_q;
    wrap_d = wrap_q;
    req_d = req_q;
    we_d = we_q;
    first_d = first_q;
    fin_d = fin_q;
    stat_d = stat_q;
    rdata_d = rxd_pkg::RST_WORD;
    if (reg_wr) begin
      case (reg_addr)
        rxd_pkg::REG_CTRL: begin
          en_d = reg_wdata[rxd_pkg::CTRL_EN];
          pass_d = reg_wdata[rxd_pkg::CTRL_PASS];
        end
        rxd_pkg::REG_BASE: begin
          base_d = reg_wdata;
          if (st_q == rxd_pkg::S_IDLE && !en_q) begin
            cur_d = reg_wdata;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        rxd_pkg::REG_CTRL: rdata_d = {30'h0, pass_q, en_q};
        rxd_pkg::REG_BASE: rdata_d = base_q;
        rxd_pkg::REG_STAT: rdata_d = {25'h0, first_q, fin_q, st_q};
        rxd_pkg::REG_CUR: rdata_d = cur_q;
        rxd_pkg::REG_FRAMES: rdata_d = {16'h0, frames_q};
        default: rdata_d = rxd_pkg::RST_WORD;
      endcase
    end
    case (st_q)
      rxd_pkg::S_IDLE: begin
        if (en_q) begin
          idx_d = 2'h0;
          req_d = 1'b1;
          we_d = 1'b0;
          addr_d = cur_q;
          st_d = rxd_pkg::S_FETCH;
        end
      end
      rxd_pkg::S_FETCH: begin
        if (mem_ack) begin
          idx_d = idx_q + 2'h1;
          addr_d = addr_q + 32'h4;
          case (idx_q)
            2'h0: own_d = mem_rdata[rxd_pkg::B_OWN];
            2'h1: begin
              wrap_d = mem_rdata[rxd_pkg::B_WRAP];
              size_d = mem_rdata[rxd_pkg::LEN_W-1:0];
            end
            2'h2: buf_d = mem_rdata;
            default: nxt_d = mem_rdata;
          endcase
          if (idx_q == 2'h3) begin
            req_d = 1'b0;
            off_d = '0;
            // not ours yet: fall back and poll the same descriptor
            if (!own_q) begin
              st_d = rxd_pkg::S_IDLE;
            end else if (size_q == '0) begin
              st_d = rxd_pkg::S_NEXT;
            end else begin
              st_d = rxd_pkg::S_DATA;
            end
          end
        end
      end
      rxd_pkg::S_DATA: begin
        if (take) begin
          req_d = 1'b1;
          we_d = 1'b1;
          addr_d = buf_q + {21'h0, off_q};
          wdata_d = rx_data;
          off_d = off_q + 11'h4;
          cnt_d = cnt_q + (rx_last ? {13'h0, rx_bytes} : 16'h4);
          fin_d = rx_last;
          if (rx_last) begin
            stat_d = rx_stat;
          end
        end else if (req_q && mem_ack) begin
          req_d = 1'b0;
          if (fin_q && drop) begin
            fin_d = 1'b0;
            cnt_d = '0;
            stat_d = '0;
            st_d = rxd_pkg::S_IDLE;
          end else if (fin_q || off_q >= size_q) begin
            req_d = 1'b1;
            addr_d = cur_q;
            wdata_d = status_word(first_q, fin_q, stat_q, cnt_q);
            st_d = rxd_pkg::S_WBACK;
          end
        end
      end
      rxd_pkg::S_WBACK: begin
        if (mem_ack) begin
          req_d = 1'b0;
          first_d = fin_q;
          if (fin_q) begin
            frames_d = frames_q + 16'h1;
            cnt_d = '0;
            stat_d = '0;
          end
          fin_d = 1'b0;
          st_d = rxd_pkg::S_NEXT;
        end
      end
      rxd_pkg::S_NEXT: begin
        cur_d = wrap_q ? base_q : nxt_q;
        st_d = rxd_pkg::S_IDLE;
      end
      default: st_d = rxd_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= rxd_pkg::S_IDLE;
      base_q <= rxd_pkg::RST_WORD;
      cur_q <= rxd_pkg::RST_WORD;
      buf_q <= rxd_pkg::RST_WORD;
      nxt_q <= rxd_pkg::RST_WORD;
      addr_q <= rxd_pkg::RST_WORD;
      wdata_q <= rxd_pkg::RST_WORD;
      rdata_q <= rxd_pkg::RST_WORD;
      cnt_q <= '0;
      frames_q <= '0;
      size_q <= '0;
      off_q <= '0;
      idx_q <= '0;
      en_q <= 1'b0;
      pass_q <= 1'b0;
      own_q <= 1'b0;
      wrap_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      first_q <= 1'b1;
      fin_q <= 1'b0;
      stat_q <= '0;
    end else begin
      st_q <= st_d;
      base_q <= base_d;
      cur_q <= cur_d;
      buf_q <= buf_d;
      nxt_q <= nxt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      cnt_q <= cnt_d;
      frames_q <= frames_d;
      size_q <= size_d;
      off_q <= off_d;
      idx_q <= idx_d;
      en_q <= en_d;
      pass_q <= pass_d;
      own_q <= own_d;
      wrap_q <= wrap_d;
      req_q <= req_d;
      we_q <= we_d;
      first_q <= first_d;
      fin_q <= fin_d;
      stat_q <= stat_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wb_issue;
    st_q == rxd_pkg::S_WBACK && req_q;
  endsequence
  sequence s_fetch_done;
    st_q == rxd_pkg::S_FETCH && mem_ack && idx_q == 2'h3;
  endsequence
  sequence s_drop_done;
    st_q == rxd_pkg::S_DATA && req_q && mem_ack && fin_q && drop;
  endsequence

  a_own_handback: assert property (s_wb_issue |-> !wdata_q[rxd_pkg::B_OWN])
    else $error("handback left own flag set");
  a_first_mark: assert property (s_wb_issue |-> wdata_q[rxd_pkg::B_FIRST] == first_q)
    else $error("first flag wrong");
  a_last_mark: assert property (s_wb_issue |-> wdata_q[rxd_pkg::B_LAST] == fin_q)
    else $error("last flag wrong");
  a_err_summary: assert property (s_wb_issue |-> wdata_q[rxd_pkg::B_ERRSUM] ==
    (wdata_q[rxd_pkg::B_CRC] | wdata_q[rxd_pkg::B_RUNT] | wdata_q[rxd_pkg::B_OVERLEN]))
    else $error("error summary mismatch");
  a_len_flag: assert property (s_wb_issue and fin_q |->
    wdata_q[rxd_pkg::B_OVERLEN] == (cnt_q > rxd_pkg::MAX_LEN) && wdata_q[10:0] == cnt_q[10:0])
    else $error("length or overlength wrong");
  a_zero_skip: assert property (s_fetch_done and (own_q && size_q == '0)
    |=> st_q == rxd_pkg::S_NEXT ##1 st_q == rxd_pkg::S_IDLE)
    else $error("zero-size buffer not skipped");
  a_no_host_fill: assert property (s_fetch_done and !own_q |=> st_q == rxd_pkg::S_IDLE)
    else $error("host-owned descriptor used");
  a_ring_wrap: assert property (st_q == rxd_pkg::S_NEXT && wrap_q |=> cur_q == $past(base_q))
    else $error("ring did not wrap to base");
  a_next_link: assert property (st_q == rxd_pkg::S_NEXT && !wrap_q |=> cur_q == $past(nxt_q))
    else $error("next descriptor not followed");
  a_data_addr: assert property (take |=> req_q && we_q &&
    addr_q == $past(buf_q) + {21'h0, $past(off_q)} && wdata_q == $past(rx_data))
    else $error("data written to wrong address");
  a_type_flag: assert property (s_wb_issue and fin_q |-> wdata_q[rxd_pkg::B_TYPE] ==
    (!stat_q.runt && stat_q.type_len > rxd_pkg::TYPE_THR))
    else $error("frame type flag wrong");
  a_phy_flag: assert property (s_wb_issue |-> wdata_q[rxd_pkg::B_PHYERR] == stat_q.phy_err)
    else $error("phy error flag wrong");
  a_runt_drop: assert property (s_drop_done |=> st_q == rxd_pkg::S_IDLE && !mem_req)
    else $error("dropped runt handed back");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("memory request not held");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule // rxd_engine
`default_nettype wire
